/* File: hdl/dac_cfg_pkg.sv */
// Constants for the octal DAC configuration word control block
package dac_cfg_pkg;
   localparam int          DATA_W        = 12;
   localparam int          NUM_CH        = 8;
   // Configuration word bit positions
   localparam int          BIT_READBACK  = 11;
   localparam int          BIT_SYNC_LD   = 10;
   localparam int          BIT_SW_RESET  = 9;
   localparam int          BIT_PD_A      = 8;
   localparam int          BIT_PD_B      = 7;
   localparam int          BIT_CORR_EN   = 6;
   localparam int          BIT_GBUSY     = 5;
   localparam int          BIT_SPAN_A    = 4;
   localparam int          BIT_SPAN_B    = 3;
   localparam logic [11:0] CFG_RESET     = 12'h800;
   localparam logic [11:0] CFG_WR_MASK   = 12'hdd8;
   localparam logic [11:0] ZERO_RESET    = 12'h000;
   localparam logic [11:0] GAIN_RESET    = 12'h800;
   // Correction time per channel
   localparam int          CORR_TIME_NS  = 500;
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          CORR_CYCLES   = CORR_TIME_NS / CLK_PERIOD_NS;
   // Register select codes on the host access port
   localparam logic [1:0]  SEL_CONFIG    = 2'h0;
   localparam logic [1:0]  SEL_INPUT     = 2'h1;
   localparam logic [1:0]  SEL_ZERO      = 2'h2;
   localparam logic [1:0]  SEL_GAIN      = 2'h3;
   // Arbitrary factory offset trim defaults
   localparam logic [11:0] OFFS_TRIM_X6  = 12'h555;
   localparam logic [11:0] OFFS_TRIM_X4  = 12'h400;
endpackage : dac_cfg_pkg

/* File: hdl/octal_dac_config_control.sv */
// Configuration word, latch update and correction sequencing for an octal DAC
//
// Function
// - Readback select 0: channel read returns its input data register.
// - Readback select 1: channel read returns its DAC data register.
// - With correction on, input register keeps raw data; DAC register gets corrected.
// - Load pin high: sync load bit copies accessed DAC registers into latches together.
// - Load refreshes only channels accessed since the previous load event.
// - Sync load bit clears itself after the latch update.
// - Sync load bit write ignored while load pin is low.
// - Correction off: sync load updates latches at chip-select rising edge.
// - Software reset bit resets whole device, then reads back 0.
// - Group A power-down disables channels 0 to 3 outputs.
// - Group B power-down disables channels 4 to 7 outputs.
// - Correction on: data adjusted by gain and zero, then to DAC register.
// - Correction off: input copied unmodified into DAC register.
// - Global busy reads 1 while any channel awaits correction.
// - Global busy forced 0 while correction disabled.
// - Group A span select: x6 when 0, x4 when 1.
// - Group A span change reloads group A offset with trim value.
// - Group B span select: x6 when 0, x4 when 1.
// - Group B span change reloads group B offset with trim value.
// - Lowest three configuration bits ignore writes and read 0.
// - Configuration word resets to 800h.
// - Correction on: input, zero or gain write sets channel busy until done.
// - Each channel correction takes about 500 ns.
`timescale 1ns/100ps
`default_nettype none
module octal_dac_config_control #(
   parameter int NUM_CH = dac_cfg_pkg::NUM_CH
) (
   // Clock and reset
   input  wire  logic                  clk_sys,
   input  wire  logic                  arst_n,
   // Host access port, write taken when chip select rises
   input  wire  logic                  cs_n,
   input  wire  logic                  wr_n,
   input  wire  logic [1:0]            reg_sel,
   input  wire  logic [2:0]            ch_sel,
   input  wire  logic [11:0]           wr_data,
   output logic       [11:0]           cfg_rd_data,
   output logic       [11:0]           ch_rd_data,
   // Load pin
   input  wire  logic                  async_load_pin_n,
   // Analog side
   output logic [NUM_CH-1:0][11:0]     latch_data,
   output logic [NUM_CH-1:0]           out_buf_en,
   output logic                        span_x4_a,
   output logic                        span_x4_b,
   output logic       [11:0]           offset_a,
   output logic       [11:0]           offset_b,
   output logic [NUM_CH-1:0]           channel_busy_flag
);
   localparam int CW = $clog2(dac_cfg_pkg::CORR_CYCLES + 1);

   typedef enum logic [1:0] {
      CE_IDLE = 2'b00,
      CE_RUN  = 2'b01
   } corr_state_e;

   logic [11:0]              cfg_reg, cfg_next;
   logic [NUM_CH-1:0][11:0]  in_reg, in_next;
   logic [NUM_CH-1:0][11:0]  dac_reg, dac_next;
   logic [NUM_CH-1:0][11:0]  zero_reg, zero_next;
   logic [NUM_CH-1:0][11:0]  gain_reg, gain_next;
   logic [NUM_CH-1:0][11:0]  latch_reg, latch_next;
   logic [NUM_CH-1:0]        acc_reg, acc_next;
   logic [NUM_CH-1:0]        busy_reg, busy_next;
   logic                     cs_d_reg;
   logic                     srst_reg, srst_next;
   logic                     ld_pend_reg, ld_pend_next;
   corr_state_e              st_reg, st_next;
   logic [2:0]               cch_reg, cch_next;
   logic [CW-1:0]            cnt_reg, cnt_next;
   logic [11:0]              offa_reg, offa_next, offb_reg, offb_next;
   logic [11:0]              crd_reg, crd_next;
   logic                     wr_ev;
   logic                     gbusy;
   logic                     load_ev;
   logic [11:0]              corr_val;

   assign wr_ev = cs_n && !cs_d_reg && !wr_n;
   assign gbusy = cfg_reg[dac_cfg_pkg::BIT_CORR_EN] && (|busy_reg);

   // Corrected code: data*gain/2048 + zero, clamped to the code range
   function automatic logic [11:0] correct(input logic [11:0] d, input logic [11:0] g,
                                           input logic [11:0] z);
      logic signed [25:0] p;
      p = $signed({2'b00, ({12'h000, d} * {12'h000, g}) >> 11}) + $signed({{14{z[11]}}, z});
      if (p < 0) begin
         correct = 12'h000;
      end else if (p > 26'sd4095) begin
         correct = 12'hfff;
      end else begin
         correct = p[11:0];
      end
   endfunction : correct

   assign corr_val = correct(in_reg[cch_reg], gain_reg[cch_reg], zero_reg[cch_reg]);

   always_comb begin
      cfg_next     = cfg_reg;
      in_next      = in_reg;
      dac_next     = dac_reg;
      zero_next    = zero_reg;
      gain_next    = gain_reg;
      latch_next   = latch_reg;
      acc_next     = acc_reg;
      busy_next    = busy_reg;
      srst_next    = 1'b0;
      ld_pend_next = ld_pend_reg;
      st_next      = st_reg;
      cch_next     = cch_reg;
      cnt_next     = cnt_reg;
      offa_next    = offa_reg;
      offb_next    = offb_reg;
      load_ev      = 1'b0;
      if (wr_ev) begin
         unique case (reg_sel)
            dac_cfg_pkg::SEL_CONFIG: begin
               cfg_next = wr_data & dac_cfg_pkg::CFG_WR_MASK;
               if (!async_load_pin_n) begin
                  cfg_next[dac_cfg_pkg::BIT_SYNC_LD] = 1'b0;
               end
               if (wr_data[dac_cfg_pkg::BIT_SW_RESET]) begin
                  srst_next = 1'b1;
               end
               if (wr_data[dac_cfg_pkg::BIT_SPAN_A] != cfg_reg[dac_cfg_pkg::BIT_SPAN_A]) begin
                  offa_next = wr_data[dac_cfg_pkg::BIT_SPAN_A] ? dac_cfg_pkg::OFFS_TRIM_X4
                                                               : dac_cfg_pkg::OFFS_TRIM_X6;
               end
               if (wr_data[dac_cfg_pkg::BIT_SPAN_B] != cfg_reg[dac_cfg_pkg::BIT_SPAN_B]) begin
                  offb_next = wr_data[dac_cfg_pkg::BIT_SPAN_B] ? dac_cfg_pkg::OFFS_TRIM_X4
                                                               : dac_cfg_pkg::OFFS_TRIM_X6;
               end
            end
            dac_cfg_pkg::SEL_INPUT: begin
               in_next[ch_sel] = wr_data;
               if (!cfg_reg[dac_cfg_pkg::BIT_CORR_EN]) begin
                  dac_next[ch_sel] = wr_data;
               end
               acc_next[ch_sel] = 1'b1;
            end
            dac_cfg_pkg::SEL_ZERO: begin
               zero_next[ch_sel] = wr_data;
            end
            dac_cfg_pkg::SEL_GAIN: begin
               gain_next[ch_sel] = wr_data;
            end
         endcase
         if (cfg_reg[dac_cfg_pkg::BIT_CORR_EN] && reg_sel != dac_cfg_pkg::SEL_CONFIG) begin
            busy_next[ch_sel] = 1'b1;
         end
      end
      // Correction engine: serve one busy channel at a time
      unique case (st_reg)
         CE_IDLE: begin
            if (cfg_reg[dac_cfg_pkg::BIT_CORR_EN] && |busy_reg) begin
               for (int i = NUM_CH - 1; i >= 0; i--) begin
                  if (busy_reg[i]) begin
                     cch_next = 3'(i);
                  end
               end
               cnt_next = CW'(dac_cfg_pkg::CORR_CYCLES - 1);
               st_next  = CE_RUN;
            end
         end
         CE_RUN: begin
            if (!cfg_reg[dac_cfg_pkg::BIT_CORR_EN]) begin
               st_next = CE_IDLE;
            end else if (cnt_reg != '0) begin
               cnt_next = cnt_reg - CW'(1);
            end else if (!(wr_ev && reg_sel != dac_cfg_pkg::SEL_CONFIG && ch_sel == cch_reg)) begin
               dac_next[cch_reg]  = corr_val;
               busy_next[cch_reg] = 1'b0;
               acc_next[cch_reg]  = 1'b1;
               st_next            = CE_IDLE;
            end
         end
         default: st_next = CE_IDLE;
      endcase
      if (!cfg_reg[dac_cfg_pkg::BIT_CORR_EN]) begin
         busy_next = '0;
      end
      // Sync load waits for correction to finish, then fires once
      if (cfg_reg[dac_cfg_pkg::BIT_SYNC_LD] && !gbusy && st_reg == CE_IDLE) begin
         load_ev                             = 1'b1;
         // A fresh host set in the same cycle wins over the self-clear
         if (!(wr_ev && reg_sel == dac_cfg_pkg::SEL_CONFIG)) begin
            cfg_next[dac_cfg_pkg::BIT_SYNC_LD] = 1'b0;
         end
      end
      if (!async_load_pin_n && !ld_pend_reg) begin
         load_ev = 1'b1;
      end
      ld_pend_next = !async_load_pin_n;
      if (load_ev) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (acc_reg[i]) begin
               latch_next[i] = dac_next[i];
            end
         end
         // Channels first written in this cycle stay marked for the next load
         acc_next = acc_next & ~acc_reg;
      end
   end

   always_comb begin
      crd_next = cfg_reg;
      crd_next[dac_cfg_pkg::BIT_GBUSY] = gbusy;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cs_d_reg <= 1'b1;
      end else begin
         cs_d_reg <= cs_n;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cfg_reg     <= dac_cfg_pkg::CFG_RESET;
         in_reg      <= '0;
         dac_reg     <= '0;
         zero_reg    <= {NUM_CH{dac_cfg_pkg::ZERO_RESET}};
         gain_reg    <= {NUM_CH{dac_cfg_pkg::GAIN_RESET}};
         latch_reg   <= '0;
         acc_reg     <= '0;
         busy_reg    <= '0;
         srst_reg    <= 1'b0;
         ld_pend_reg <= 1'b0;
         st_reg      <= CE_IDLE;
         cch_reg     <= 3'h0;
         cnt_reg     <= '0;
         offa_reg    <= dac_cfg_pkg::OFFS_TRIM_X6;
         offb_reg    <= dac_cfg_pkg::OFFS_TRIM_X6;
         crd_reg     <= dac_cfg_pkg::CFG_RESET;
      end else if (srst_reg) begin
         cfg_reg     <= dac_cfg_pkg::CFG_RESET;
         in_reg      <= '0;
         dac_reg     <= '0;
         zero_reg    <= {NUM_CH{dac_cfg_pkg::ZERO_RESET}};
         gain_reg    <= {NUM_CH{dac_cfg_pkg::GAIN_RESET}};
         latch_reg   <= '0;
         acc_reg     <= '0;
         busy_reg    <= '0;
         srst_reg    <= 1'b0;
         ld_pend_reg <= 1'b0;
         st_reg      <= CE_IDLE;
         cch_reg     <= 3'h0;
         cnt_reg     <= '0;
         offa_reg    <= dac_cfg_pkg::OFFS_TRIM_X6;
         offb_reg    <= dac_cfg_pkg::OFFS_TRIM_X6;
         crd_reg     <= dac_cfg_pkg::CFG_RESET;
      end else begin
         cfg_reg     <= cfg_next;
         in_reg      <= in_next;
         dac_reg     <= dac_next;
         zero_reg    <= zero_next;
         gain_reg    <= gain_next;
         latch_reg   <= latch_next;
         acc_reg     <= acc_next;
         busy_reg    <= busy_next;
         srst_reg    <= srst_next;
         ld_pend_reg <= ld_pend_next;
         st_reg      <= st_next;
         cch_reg     <= cch_next;
         cnt_reg     <= cnt_next;
         offa_reg    <= offa_next;
         offb_reg    <= offb_next;
         crd_reg     <= crd_next;
      end
   end

   // Registered outputs
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ch_rd_data <= 12'h000;
         out_buf_en <= '0;
      end else begin
         ch_rd_data <= cfg_reg[dac_cfg_pkg::BIT_READBACK] ? dac_reg[ch_sel]
                                                          : in_reg[ch_sel];
         for (int i = 0; i < NUM_CH; i++) begin
            out_buf_en[i] <= (i < NUM_CH / 2) ? !cfg_reg[dac_cfg_pkg::BIT_PD_A]
                                              : !cfg_reg[dac_cfg_pkg::BIT_PD_B];
         end
      end
   end

   assign cfg_rd_data       = crd_reg;
   assign latch_data        = latch_reg;
   assign span_x4_a         = cfg_reg[dac_cfg_pkg::BIT_SPAN_A];
   assign span_x4_b         = cfg_reg[dac_cfg_pkg::BIT_SPAN_B];
   assign offset_a          = offa_reg;
   assign offset_b          = offb_reg;
   assign channel_busy_flag = busy_reg;

   a_cfg_reserved_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cfg_rd_data[2:0] == 3'b000) else $error("Reserved config bits nonzero");
   a_gbusy_forced_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !cfg_reg[dac_cfg_pkg::BIT_CORR_EN] |=> !cfg_rd_data[dac_cfg_pkg::BIT_GBUSY])
      else $error("Global busy set while correction off");
   a_sync_ld_ignored: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (wr_ev && reg_sel == dac_cfg_pkg::SEL_CONFIG && !async_load_pin_n && !srst_reg)
      |=> !cfg_reg[dac_cfg_pkg::BIT_SYNC_LD]) else $error("Sync load kept with pin low");
   a_sync_ld_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (cfg_reg[dac_cfg_pkg::BIT_SYNC_LD] && !gbusy && st_reg == CE_IDLE && !wr_ev)
      |=> !cfg_reg[dac_cfg_pkg::BIT_SYNC_LD]) else $error("Sync load did not clear");
   a_sw_reset_value: assert property (@(posedge clk_sys) disable iff (!arst_n)
      srst_reg |=> cfg_reg == dac_cfg_pkg::CFG_RESET && busy_reg == '0)
      else $error("Software reset incomplete");
   a_raw_copy_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (wr_ev && reg_sel == dac_cfg_pkg::SEL_INPUT && !srst_reg
       && !cfg_reg[dac_cfg_pkg::BIT_CORR_EN])
      |=> dac_reg[$past(ch_sel)] == $past(wr_data)) else $error("Raw copy missing");
   a_busy_set_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (wr_ev && reg_sel != dac_cfg_pkg::SEL_CONFIG && !srst_reg
       && cfg_reg[dac_cfg_pkg::BIT_CORR_EN])
      |=> busy_reg[$past(ch_sel)]) else $error("Channel busy not set");
   a_busy_time_bound: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (st_reg == CE_IDLE ##1 st_reg == CE_RUN) |-> ##[49:50] st_reg != CE_RUN || cnt_reg == '0)
      else $error("Correction time wrong");
   a_readback_sel: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $past(cfg_reg[dac_cfg_pkg::BIT_READBACK]) && !$past(srst_reg)
      |-> ch_rd_data == $past(dac_reg[ch_sel])) else $error("Readback source wrong");
   a_readback_raw: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !$past(cfg_reg[dac_cfg_pkg::BIT_READBACK])
      |-> ch_rd_data == $past(in_reg[ch_sel])) else $error("Raw readback wrong");
endmodule : octal_dac_config_control
`default_nettype wire

/* File: verif/host_bus_model.sv */
// Host processor model driving the parallel write port and the load pin
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
   // Clock
   input  wire logic        clk_sys,
   // Status read back by the host
   input  wire logic [11:0] cfg_rd_data,
   // Parallel write port
   output var  logic        cs_n,
   output var  logic        wr_n,
   output var  logic [1:0]  reg_sel,
   output var  logic [2:0]  ch_sel,
   output var  logic [11:0] wr_data,
   // Load pin
   output var  logic        async_load_pin_n
);
   initial begin
      cs_n             = 1'b1;
      wr_n             = 1'b1;
      reg_sel          = 2'h0;
      ch_sel           = 3'h0;
      wr_data          = 12'h000;
      async_load_pin_n = 1'b1;
   end

   // One write per chip-select pulse, returns once the read path shows it
   task automatic write_reg(input logic [1:0] sel, input logic [2:0] ch, input logic [11:0] d);
      @(posedge clk_sys);
      #1;
      cs_n    = 1'b0;
      wr_n    = 1'b0;
      reg_sel = sel;
      ch_sel  = ch;
      wr_data = d;
      @(posedge clk_sys);
      #1;
      cs_n = 1'b1;
      @(posedge clk_sys);
      #1;
      wr_n    = 1'b1;
      wr_data = ~d;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : write_reg

   // Point the channel readback at one channel
   task automatic show_ch(input logic [2:0] ch);
      @(posedge clk_sys);
      #1;
      ch_sel = ch;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : show_ch

   task automatic set_load(input logic v);
      @(posedge clk_sys);
      #1;
      async_load_pin_n = v;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : set_load

   // Host waits for correction to finish before a sync load
   task automatic wait_idle(output int n);
      n = 0;
      while (cfg_rd_data[5] !== 1'b0 && n < 1000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask : wait_idle
endmodule : host_bus_model
`default_nettype wire

/* File: verif/octal_dac_config_control_tb.sv */
// Self-checking testbench for the octal DAC configuration control block
`timescale 1ns/100ps
`default_nettype none
module octal_dac_config_control_tb;
   logic             clk_sys = 1'b0;
   logic             arst_n  = 1'b0;
   logic             cs_n, wr_n, async_load_pin_n;
   logic [1:0]       reg_sel;
   logic [2:0]       ch_sel;
   logic [11:0]      wr_data, cfg_rd_data, ch_rd_data, offset_a, offset_b;
   logic [7:0][11:0] latch_data;
   logic [7:0]       out_buf_en, channel_busy_flag;
   logic             span_x4_a, span_x4_b;
   int               n_mismatch = 0;
   int               n_compared = 0;
   int               n;

   always #5 clk_sys = ~clk_sys;

   host_bus_model i_host (.clk_sys(clk_sys), .cfg_rd_data(cfg_rd_data), .cs_n(cs_n),
      .wr_n(wr_n), .reg_sel(reg_sel), .ch_sel(ch_sel), .wr_data(wr_data),
      .async_load_pin_n(async_load_pin_n));

   octal_dac_config_control i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .cs_n(cs_n),
      .wr_n(wr_n), .reg_sel(reg_sel), .ch_sel(ch_sel), .wr_data(wr_data),
      .cfg_rd_data(cfg_rd_data), .ch_rd_data(ch_rd_data),
      .async_load_pin_n(async_load_pin_n), .latch_data(latch_data),
      .out_buf_en(out_buf_en), .span_x4_a(span_x4_a), .span_x4_b(span_x4_b),
      .offset_a(offset_a), .offset_b(offset_b), .channel_busy_flag(channel_busy_flag));

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cfg_wr(input logic [11:0] d);
      i_host.write_reg(dac_cfg_pkg::SEL_CONFIG, 3'h0, d);
   endtask : cfg_wr

   task automatic t_reset();
      chk(cfg_rd_data, dac_cfg_pkg::CFG_RESET);
      chk(offset_a, dac_cfg_pkg::OFFS_TRIM_X6);
      chk({4'h0, out_buf_en}, 12'h0ff);
   endtask : t_reset

   task automatic t_cfg_bits();
      cfg_wr(12'h0a7);
      chk(cfg_rd_data, 12'h080);
      chk({4'h0, out_buf_en}, 12'h00f);
      cfg_wr(12'h900);
      chk(cfg_rd_data, 12'h900);
      chk({4'h0, out_buf_en}, 12'h0f0);
      cfg_wr(12'h800);
      chk({4'h0, out_buf_en}, 12'h0ff);
   endtask : t_cfg_bits

   task automatic t_span();
      cfg_wr(12'h810);
      chk({11'h0, span_x4_a}, 12'h001);
      chk(offset_a, dac_cfg_pkg::OFFS_TRIM_X4);
      cfg_wr(12'h808);
      chk({11'h0, span_x4_a}, 12'h000);
      chk(offset_a, dac_cfg_pkg::OFFS_TRIM_X6);
      chk({11'h0, span_x4_b}, 12'h001);
      chk(offset_b, dac_cfg_pkg::OFFS_TRIM_X4);
      cfg_wr(12'h800);
      chk(offset_b, dac_cfg_pkg::OFFS_TRIM_X6);
   endtask : t_span

   task automatic t_sync_load();
      i_host.write_reg(dac_cfg_pkg::SEL_INPUT, 3'h2, 12'h123);
      chk(latch_data[2], 12'h000);
      i_host.show_ch(3'h2);
      chk(ch_rd_data, 12'h123);
      cfg_wr(12'hc00);
      chk(latch_data[2], 12'h123);
      chk(latch_data[3], 12'h000);
      chk(cfg_rd_data, 12'h800);
   endtask : t_sync_load

   task automatic t_load_pin();
      i_host.write_reg(dac_cfg_pkg::SEL_INPUT, 3'h4, 12'h3c3);
      i_host.set_load(1'b0);
      chk(latch_data[4], 12'h3c3);
      i_host.write_reg(dac_cfg_pkg::SEL_INPUT, 3'h3, 12'h456);
      cfg_wr(12'hc00);
      chk(latch_data[3], 12'h000);
      chk(cfg_rd_data, 12'h800);
      i_host.set_load(1'b1);
      cfg_wr(12'hc00);
      chk(latch_data[3], 12'h456);
      chk(latch_data[2], 12'h123);
   endtask : t_load_pin

   // Bounded wait for the correction engine; a timeout ends the run as a failure
   task automatic wait_corr();
      i_host.wait_idle(n);
      if (n >= 1000) begin
         n_mismatch++;
         print_verdict();
      end
   endtask : wait_corr

   task automatic t_correction();
      cfg_wr(12'h840);
      i_host.write_reg(dac_cfg_pkg::SEL_ZERO, 3'h1, 12'h010);
      chk({11'h0, channel_busy_flag[1]}, 12'h001);
      wait_corr();
      i_host.write_reg(dac_cfg_pkg::SEL_INPUT, 3'h1, 12'h100);
      chk({11'h0, channel_busy_flag[1]}, 12'h001);
      chk(cfg_rd_data, 12'h860);
      wait_corr();
      chk({11'h0, n >= 40 && n <= 52}, 12'h001);
      chk(cfg_rd_data, 12'h840);
      i_host.show_ch(3'h1);
      chk(ch_rd_data, 12'h110);
      cfg_wr(12'h040);
      i_host.show_ch(3'h1);
      chk(ch_rd_data, 12'h100);
      chk(ch_rd_data, 12'h100);
      cfg_wr(12'hc40);
      chk(latch_data[1], 12'h110);
      cfg_wr(12'h860);
      chk(cfg_rd_data, 12'h840);
      i_host.write_reg(dac_cfg_pkg::SEL_INPUT, 3'h6, 12'h0aa);
      cfg_wr(12'h820);
      chk(cfg_rd_data, 12'h800);
   endtask : t_correction

   task automatic t_sw_reset();
      cfg_wr(12'h910);
      cfg_wr(12'h200);
      chk(cfg_rd_data, dac_cfg_pkg::CFG_RESET);
      chk(offset_a, dac_cfg_pkg::OFFS_TRIM_X6);
      chk(latch_data[2], 12'h000);
   endtask : t_sw_reset

   initial begin
      repeat (4) @(posedge clk_sys);
      #1;
      arst_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      t_reset();
      t_cfg_bits();
      t_span();
      t_sync_load();
      t_load_pin();
      t_correction();
      t_sw_reset();
      print_verdict();
   end
endmodule : octal_dac_config_control_tb
`default_nettype wire
